// ---- core/conv_speed_sel_top.sv ----
// Converter sequencer top: APB registers, channel sequence, results
`timescale 1ns/1ps
// Overview of operation
// - Eight-bit result from 256-step ladder search
// - Fixed mode converts only selected input
// - Scan runs from input 0 or 4
// - Reset clears channel selection to input 0
// - Writing start sets busy during conversion
// - Single or repeat in fixed and scan
// - Speed bit resets to high speed
// - Single finish: end set, busy cleared, irq
// - Done irq cleared by reset or result read
// - Repeat mode raises no done irq
// - Repeat off takes effect after the last channel of the current pass
// - Result stored per channel pair (inputs n and n+4 share one), overwritten on repeat
// - Result registers ignore software writes
// - Any result read clears end flag
// - Unused analog pins read as digital port
module conv_speed_sel_top
    import conv_speed_sel_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cmp_i,
    input wire logic [7:0] pins_i,
    output logic [7:0] dac_code_o,
    output logic [2:0] mux_sel_o,
    output logic [7:0] ain_en_o,
    output logic irq_o
);

    conv_speed_sel_mode_t mode_ff;
    conv_speed_sel_seq_st_t st_ff;
    logic busy_ff;
    logic end_ff;
    logic [CONV_SPEED_SEL_EV_N-1:0] irq_stat_ff;
    logic [CONV_SPEED_SEL_EV_N-1:0] irq_en_ff;
    logic [2:0] chan_ff;
    logic kick_ff;
    logic [7:0] res_ff [CONV_SPEED_SEL_RES_N];
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [7:0] mask_ff;
    logic irq_ff;

    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic res_rd;
    logic trig;
    logic [2:0] first_ch;
    logic [2:0] last_ch;
    logic [7:0] use_mask;
    logic sar_done;
    logic [7:0] sar_code;
    logic scan_end;
    logic [31:0] nxt_rdata;
    conv_speed_sel_mode_t wmode;

    // Bus phases: data prepared in setup, access completes in one cycle
    assign setup = psel_i && !penable_i;
    assign acc = psel_i && penable_i && pready_ff;
    assign wr = acc && pwrite_i && mapped;
    assign rd = acc && !pwrite_i && mapped;
    assign res_rd = rd && (paddr_i >= CONV_SPEED_SEL_OFF_RES_A) &&
        (paddr_i <= CONV_SPEED_SEL_OFF_RES_D);
    assign wmode = '{
        speed: pwdata_i[CONV_SPEED_SEL_B_SPD],
        rep: pwdata_i[CONV_SPEED_SEL_B_REP],
        scan: pwdata_i[CONV_SPEED_SEL_B_SCAN],
        ch_hi: pwdata_i[CONV_SPEED_SEL_B_CH_HI],
        ch_lo: pwdata_i[CONV_SPEED_SEL_B_CH_LO +: 2]};
    assign trig = wr && (paddr_i == CONV_SPEED_SEL_OFF_MODE) &&
        pwdata_i[CONV_SPEED_SEL_B_TRIG];
    assign scan_end = (chan_ff == last_ch);

    conv_speed_sel_chan u_chan (
        .mode_i(mode_ff),
        .first_o(first_ch),
        .last_o(last_ch),
        .use_mask_o(use_mask)
    );

    conv_speed_sel_sar u_sar (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .start_i(kick_ff),
        .slow_i(mode_ff.speed),
        .cmp_i(cmp_i),
        .code_o(sar_code),
        .done_o(sar_done)
    );

    // Address decode and read data mux
    always_comb begin
        mapped = 1'b1;
        nxt_rdata = 32'h0000_0000;
        case (paddr_i)
            CONV_SPEED_SEL_OFF_MODE: begin
                nxt_rdata[CONV_SPEED_SEL_B_CH_LO +: 2] = mode_ff.ch_lo;
                nxt_rdata[CONV_SPEED_SEL_B_CH_HI] = mode_ff.ch_hi;
                nxt_rdata[CONV_SPEED_SEL_B_SCAN] = mode_ff.scan;
                nxt_rdata[CONV_SPEED_SEL_B_REP] = mode_ff.rep;
                nxt_rdata[CONV_SPEED_SEL_B_SPD] = mode_ff.speed;
                nxt_rdata[CONV_SPEED_SEL_B_TRIG] = 1'b0;
                nxt_rdata[CONV_SPEED_SEL_B_BUSY] = busy_ff;
                nxt_rdata[CONV_SPEED_SEL_B_END] = end_ff;
            end
            CONV_SPEED_SEL_OFF_IRQ_EN: nxt_rdata[CONV_SPEED_SEL_EV_N-1:0] = irq_en_ff;
            CONV_SPEED_SEL_OFF_IRQ_STAT: nxt_rdata[CONV_SPEED_SEL_EV_N-1:0] = irq_stat_ff;
            CONV_SPEED_SEL_OFF_IRQ_CLR: nxt_rdata = 32'h0000_0000;
            CONV_SPEED_SEL_OFF_RES_A: nxt_rdata[7:0] = res_ff[0];
            CONV_SPEED_SEL_OFF_RES_B: nxt_rdata[7:0] = res_ff[1];
            CONV_SPEED_SEL_OFF_RES_C: nxt_rdata[7:0] = res_ff[2];
            CONV_SPEED_SEL_OFF_RES_D: nxt_rdata[7:0] = res_ff[3];
            CONV_SPEED_SEL_OFF_PORT: nxt_rdata[7:0] = pins_i & ~mask_ff;
            default: mapped = 1'b0;
        endcase
    end

    // APB answer registers: ready in the first access cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            if (setup && !pwrite_i) begin
                prdata_ff <= nxt_rdata;
            end else if (acc) begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Mode register; start bit is a trigger only
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mode_ff <= CONV_SPEED_SEL_MODE_RST;
        end else if (wr && (paddr_i == CONV_SPEED_SEL_OFF_MODE)) begin
            mode_ff <= wmode;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_en_ff <= '0;
        end else if (wr && (paddr_i == CONV_SPEED_SEL_OFF_IRQ_EN)) begin
            irq_en_ff <= pwdata_i[CONV_SPEED_SEL_EV_N-1:0];
        end
    end

    // Sequencer: steps channels, decides repeat or finish
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_ff <= CONV_SPEED_SEL_SQ_IDLE;
            busy_ff <= 1'b0;
            chan_ff <= CONV_SPEED_SEL_CH_RST;
            kick_ff <= 1'b0;
        end else begin
            kick_ff <= 1'b0;
            case (st_ff)
                CONV_SPEED_SEL_SQ_IDLE: begin
                    if (trig) begin
                        busy_ff <= 1'b1;
                        chan_ff <= wmode.scan ? {wmode.ch_hi, 2'h0} :
                            {wmode.ch_hi, wmode.ch_lo};
                        kick_ff <= 1'b1;
                        st_ff <= CONV_SPEED_SEL_SQ_CONV;
                    end
                end
                CONV_SPEED_SEL_SQ_CONV: begin
                    if (sar_done) begin
                        if (!scan_end) begin
                            chan_ff <= chan_ff + 3'h1;
                            kick_ff <= 1'b1;
                        end else if (mode_ff.rep) begin
                            chan_ff <= first_ch;
                            kick_ff <= 1'b1;
                        end else begin
                            busy_ff <= 1'b0;
                            st_ff <= CONV_SPEED_SEL_SQ_IDLE;
                        end
                    end
                end
                default: st_ff <= CONV_SPEED_SEL_SQ_IDLE;
            endcase
        end
    end

    // End flag: set after the last channel of every pass, repeat included; result read clears, set wins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            end_ff <= 1'b0;
        end else if (st_ff == CONV_SPEED_SEL_SQ_CONV && sar_done && scan_end) begin
            end_ff <= 1'b1;
        end else if (res_rd) begin
            end_ff <= 1'b0;
        end
    end

    // Result store: shared register per channel pair, bus writes ignored
    genvar gr;
    generate
        for (gr = 0; gr < CONV_SPEED_SEL_RES_N; gr++) begin : g_res
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    res_ff[gr] <= CONV_SPEED_SEL_RES_RST;
                end else if (st_ff == CONV_SPEED_SEL_SQ_CONV && sar_done &&
                    chan_ff[1:0] == 2'(gr)) begin
                    res_ff[gr] <= sar_code;
                end
            end
        end
    endgenerate

    // Sticky events: done only clears on result read, conv by clear reg
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_stat_ff <= '0;
        end else begin
            if (st_ff == CONV_SPEED_SEL_SQ_CONV && sar_done && scan_end &&
                !mode_ff.rep) begin
                irq_stat_ff[CONV_SPEED_SEL_EV_DONE] <= 1'b1;
            end else if (res_rd) begin
                irq_stat_ff[CONV_SPEED_SEL_EV_DONE] <= 1'b0;
            end
            if (st_ff == CONV_SPEED_SEL_SQ_CONV && sar_done) begin
                irq_stat_ff[CONV_SPEED_SEL_EV_CONV] <= 1'b1;
            end else if (wr && (paddr_i == CONV_SPEED_SEL_OFF_IRQ_CLR) &&
                pwdata_i[CONV_SPEED_SEL_EV_CONV]) begin
                irq_stat_ff[CONV_SPEED_SEL_EV_CONV] <= 1'b0;
            end
        end
    end

    // Registered pin-facing outputs
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mux_sel_o <= CONV_SPEED_SEL_CH_RST;
            mask_ff <= 8'h00;
            irq_ff <= 1'b0;
        end else begin
            mux_sel_o <= chan_ff;
            mask_ff <= busy_ff ? use_mask : 8'h00;
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign dac_code_o = sar_code;
    assign ain_en_o = mask_ff;
    assign irq_o = irq_ff;

endmodule : conv_speed_sel_top

// ---- include/conv_speed_sel_pkg.sv ----
// Shared constants, types and register map of the converter sequencer
package conv_speed_sel_pkg;

    // Converter resolution and ladder size
    localparam int CONV_SPEED_SEL_RES_W = 8;
    localparam int CONV_SPEED_SEL_LADDER_STEPS = 256;
    localparam int CONV_SPEED_SEL_CHAN_N = 8;
    localparam int CONV_SPEED_SEL_RES_N = 4;
    localparam logic [7:0] CONV_SPEED_SEL_SAR_MID = 8'h80;
    localparam logic [2:0] CONV_SPEED_SEL_SAR_TOP_BIT = 3'h7;

    // Register byte offsets on the APB
    localparam logic [7:0] CONV_SPEED_SEL_OFF_MODE = 8'h00;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_IRQ_EN = 8'h04;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_RES_A = 8'h10;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_RES_B = 8'h14;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_RES_C = 8'h18;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_RES_D = 8'h1C;
    localparam logic [7:0] CONV_SPEED_SEL_OFF_PORT = 8'h20;

    // Field positions of conv_mode_reg
    localparam int CONV_SPEED_SEL_B_CH_LO = 0;
    localparam int CONV_SPEED_SEL_B_CH_HI = 2;
    localparam int CONV_SPEED_SEL_B_SCAN = 3;
    localparam int CONV_SPEED_SEL_B_REP = 4;
    localparam int CONV_SPEED_SEL_B_SPD = 5;
    localparam int CONV_SPEED_SEL_B_TRIG = 6;
    localparam int CONV_SPEED_SEL_B_BUSY = 7;
    localparam int CONV_SPEED_SEL_B_END = 8;

    // Interrupt status, enable and clear bit positions
    localparam int CONV_SPEED_SEL_EV_DONE = 0;
    localparam int CONV_SPEED_SEL_EV_CONV = 1;
    localparam int CONV_SPEED_SEL_EV_N = 2;

    // Per-bit comparison step times, least values
    localparam int CONV_SPEED_SEL_CLK_NS = 100;
    localparam int CONV_SPEED_SEL_HS_STEP_NS = 100;
    localparam int CONV_SPEED_SEL_LS_STEP_NS = 400;
    localparam int CONV_SPEED_SEL_HS_STEP_CYC =
        (CONV_SPEED_SEL_HS_STEP_NS + CONV_SPEED_SEL_CLK_NS - 1) / CONV_SPEED_SEL_CLK_NS;
    localparam int CONV_SPEED_SEL_LS_STEP_CYC =
        (CONV_SPEED_SEL_LS_STEP_NS + CONV_SPEED_SEL_CLK_NS - 1) / CONV_SPEED_SEL_CLK_NS;
    localparam logic [2:0] CONV_SPEED_SEL_HS_RELOAD = 3'(CONV_SPEED_SEL_HS_STEP_CYC - 1);
    localparam logic [2:0] CONV_SPEED_SEL_LS_RELOAD = 3'(CONV_SPEED_SEL_LS_STEP_CYC - 1);

    // Reset values
    localparam logic [7:0] CONV_SPEED_SEL_RES_RST = 8'h00;
    localparam logic [2:0] CONV_SPEED_SEL_CH_RST = 3'h0;

    // Mode fields as written by software
    typedef struct packed {
        logic speed;
        logic rep;
        logic scan;
        logic ch_hi;
        logic [1:0] ch_lo;
    } conv_speed_sel_mode_t;

    localparam conv_speed_sel_mode_t CONV_SPEED_SEL_MODE_RST = '{
        speed: 1'b0, rep: 1'b0, scan: 1'b0, ch_hi: 1'b0, ch_lo: 2'h0};

    typedef enum logic [1:0] {CONV_SPEED_SEL_SQ_IDLE, CONV_SPEED_SEL_SQ_CONV} conv_speed_sel_seq_st_t;
    typedef enum logic [1:0] {CONV_SPEED_SEL_SAR_IDLE, CONV_SPEED_SEL_SAR_TRIAL} conv_speed_sel_sar_st_t;

endpackage : conv_speed_sel_pkg

// ---- core/conv_speed_sel_sar.sv ----
// Successive-approximation engine driving the reference ladder code
`timescale 1ns/1ps
module conv_speed_sel_sar
    import conv_speed_sel_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic cmp_i,
    output logic [7:0] code_o,
    output logic done_o
);

    conv_speed_sel_sar_st_t st_ff;
    logic [7:0] code_ff;
    logic [2:0] bit_ff;
    logic [2:0] wait_ff;

    // Binary search: one ladder bit per step, 256 levels in 8 trials
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_ff <= CONV_SPEED_SEL_SAR_IDLE;
            code_ff <= CONV_SPEED_SEL_RES_RST;
            bit_ff <= CONV_SPEED_SEL_SAR_TOP_BIT;
            wait_ff <= CONV_SPEED_SEL_HS_RELOAD;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st_ff)
                CONV_SPEED_SEL_SAR_IDLE: begin
                    if (start_i) begin
                        code_ff <= CONV_SPEED_SEL_SAR_MID;
                        bit_ff <= CONV_SPEED_SEL_SAR_TOP_BIT;
                        wait_ff <= slow_i ? CONV_SPEED_SEL_LS_RELOAD : CONV_SPEED_SEL_HS_RELOAD;
                        st_ff <= CONV_SPEED_SEL_SAR_TRIAL;
                    end
                end
                CONV_SPEED_SEL_SAR_TRIAL: begin
                    if (wait_ff != 3'h0) begin
                        wait_ff <= wait_ff - 3'h1;
                    end else begin
                        // Input below trial level drops the bit
                        if (!cmp_i) begin
                            code_ff[bit_ff] <= 1'b0;
                        end
                        if (bit_ff == 3'h0) begin
                            done_o <= 1'b1;
                            st_ff <= CONV_SPEED_SEL_SAR_IDLE;
                        end else begin
                            code_ff[bit_ff - 3'h1] <= 1'b1;
                            bit_ff <= bit_ff - 3'h1;
                            wait_ff <= slow_i ? CONV_SPEED_SEL_LS_RELOAD :
                                CONV_SPEED_SEL_HS_RELOAD;
                        end
                    end
                end
                default: st_ff <= CONV_SPEED_SEL_SAR_IDLE;
            endcase
        end
    end

    assign code_o = code_ff;

endmodule : conv_speed_sel_sar

// ---- core/conv_speed_sel_chan.sv ----
// Channel range decoder for fixed and scan operation
`timescale 1ns/1ps
module conv_speed_sel_chan
    import conv_speed_sel_pkg::*;
(
    input conv_speed_sel_mode_t mode_i,
    output logic [2:0] first_o,
    output logic [2:0] last_o,
    output logic [7:0] use_mask_o
);

    // Scan starts at input 0 or 4; last channel grows with the code
    assign first_o = mode_i.scan ? {mode_i.ch_hi, 2'h0} :
        {mode_i.ch_hi, mode_i.ch_lo};
    assign last_o = {mode_i.ch_hi, mode_i.ch_lo};

    // Inputs inside the active range are claimed for conversion
    genvar gi;
    generate
        for (gi = 0; gi < CONV_SPEED_SEL_CHAN_N; gi++) begin : g_mask
            assign use_mask_o[gi] = (3'(gi) >= first_o) &&
                (3'(gi) <= last_o);
        end
    endgenerate

endmodule : conv_speed_sel_chan

// ---- tb/conv_speed_sel_check_assertions.sv ----
// Port-level checks of the converter sequencer top
`timescale 1ns/1ps
module conv_speed_sel_check
    import conv_speed_sel_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [7:0] pins_i,
    input wire logic [7:0] dac_code_o,
    input wire logic [2:0] mux_sel_o,
    input wire logic [7:0] ain_en_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic rd_acc;
    logic [7:0] port_exp_ff;
    // Read access cycle and the port value seen at its setup edge
    assign rd_acc = pready_o && psel_i && !pwrite_i;
    always_ff @(posedge clk_i) begin
        port_exp_ff <= pins_i & ~ain_en_o;
    end

    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    a_write_no_data: assert property (pready_o && pwrite_i |-> !(|prdata_o))
        else $error("read data on a write");
    a_unmapped_error: assert property (pready_o
        |-> pslverr_o == (paddr_i > CONV_SPEED_SEL_OFF_PORT || paddr_i[1:0] != 2'h0))
        else $error("slave error wrong");
    a_trigger_reads_zero: assert property (
        rd_acc && paddr_i == CONV_SPEED_SEL_OFF_MODE |-> !prdata_o[CONV_SPEED_SEL_B_TRIG])
        else $error("trigger bit read back set");
    a_result_eight_bit: assert property (
        rd_acc && paddr_i[7:4] == 4'h1 |-> prdata_o[31:8] == 24'h0)
        else $error("result wider than eight bits");
    a_port_masked: assert property (
        rd_acc && paddr_i == CONV_SPEED_SEL_OFF_PORT
        |-> prdata_o == {24'h0, port_exp_ff})
        else $error("port read wrong");
    a_reset_idle: assert property (
        !$past(nrst_i) |-> mux_sel_o == 3'h0 && ain_en_o == 8'h0 && !irq_o)
        else $error("outputs not idle after reset");
    a_first_trial_mid: assert property (
        $rose(|ain_en_o) |-> ##[0:3] dac_code_o == CONV_SPEED_SEL_SAR_MID)
        else $error("first trial code wrong");
    a_mux_in_set: assert property (
        (|ain_en_o) && (|$past(ain_en_o)) && (|$past(ain_en_o, 2))
        |-> ain_en_o[mux_sel_o])
        else $error("mux outside active set");
    a_idle_code_holds: assert property (
        !(|ain_en_o) && !(|$past(ain_en_o)) |-> $stable(dac_code_o))
        else $error("ladder code moved while idle");
endmodule : conv_speed_sel_check

bind conv_speed_sel_top conv_speed_sel_check conv_speed_sel_check_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pins_i(pins_i), .dac_code_o(dac_code_o),
    .mux_sel_o(mux_sel_o), .ain_en_o(ain_en_o), .irq_o(irq_o));

// ---- tb/conv_speed_sel_ladder.sv ----
// Analog inputs, reference ladder and comparator model
`timescale 1ns/1ps
module conv_speed_sel_ladder (
    input wire logic [63:0] level_i,
    input wire logic [2:0] mux_sel_i,
    input wire logic [7:0] code_i,
    output logic cmp_o,
    output logic [7:0] pins_o
);
    logic [7:0] vin;
    // Selected input against the 256-step ladder tap
    assign vin = level_i[{mux_sel_i, 3'h0} +: 8];
    assign cmp_o = (vin >= code_i);
    // Digital reading of each pin: upper half of the span reads high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins_o[i] = level_i[8 * i + 7];
        end
    end
endmodule : conv_speed_sel_ladder

// ---- tb/tb.sv ----
// Register-level testbench of the converter sequencer
`timescale 1ns/1ps
module tb;
    import conv_speed_sel_pkg::*;
    logic clk, nrst, psel, penable, pwrite, cmp, pready, pslverr, irq, e;
    logic [7:0] paddr, pins, dac, ain_en, x;
    logic [2:0] mux;
    logic [31:0] pwdata, prdata, r;
    logic [63:0] lvl;
    int error_cnt = 0;
    int cmp_count = 0;

    conv_speed_sel_top conv_speed_sel_top_i (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cmp_i(cmp), .pins_i(pins),
        .dac_code_o(dac), .mux_sel_o(mux), .ain_en_o(ain_en), .irq_o(irq));
    conv_speed_sel_ladder conv_speed_sel_ladder_i (.level_i(lvl), .mux_sel_i(mux),
        .code_i(dac), .cmp_o(cmp), .pins_o(pins));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done;
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    task automatic chk(input string s, input logic [31:0] x, y);
        cmp_count++;
        if (y !== x) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", s, x, y);
        end
    endtask : chk

    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic er);
        logic rdy;
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        rdy = 1'b0;
        n = 0;
        while (rdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            rdy = pready;
            q = prdata;
            er = pslverr;
            n++;
        end
        if (rdy !== 1'b1) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, q, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic er;
        apb(1'b0, a, 32'h0, q, er);
    endtask : rd

    // Poll until busy clears, bounded
    task automatic wait_idle(output logic [31:0] q);
        q = 32'h80;
        for (int n = 0; n < 200 && q[CONV_SPEED_SEL_B_BUSY] !== 1'b0; n++) begin
            rd(CONV_SPEED_SEL_OFF_MODE, q);
        end
        if (q[CONV_SPEED_SEL_B_BUSY] !== 1'b0) error_cnt++;
    endtask : wait_idle

    // Clear the conversion event, then wait for the next one
    task automatic wait_evt;
        logic [31:0] q;
        wr(CONV_SPEED_SEL_OFF_IRQ_CLR, 32'h2);
        q = 32'h0;
        for (int n = 0; n < 100 && q[CONV_SPEED_SEL_EV_CONV] !== 1'b1; n++) begin
            rd(CONV_SPEED_SEL_OFF_IRQ_STAT, q);
        end
        if (q[CONV_SPEED_SEL_EV_CONV] !== 1'b1) error_cnt++;
    endtask : wait_evt

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    // Main sequence
    initial begin
        nrst <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        lvl = 64'h7F80FE01A55AFF00;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(CONV_SPEED_SEL_OFF_MODE, r);
        chk("mode", 32'h0, r);
        wr(CONV_SPEED_SEL_OFF_IRQ_EN, 32'h1);
        wr(CONV_SPEED_SEL_OFF_MODE, 32'h43);
        rd(CONV_SPEED_SEL_OFF_MODE, r);
        chk("mode_busy", 32'h83, r);
        wait_idle(r);
        chk("mode_end", 32'h103, r);
        chk("irq_done", 32'h1, {31'h0, irq});
        wr(CONV_SPEED_SEL_OFF_IRQ_CLR, 32'h3);
        rd(CONV_SPEED_SEL_OFF_IRQ_STAT, r);
        chk("stat_kept", 32'h1, r);
        wr(CONV_SPEED_SEL_OFF_RES_D, 32'h0);
        rd(CONV_SPEED_SEL_OFF_RES_D, r);
        chk("res_d", {24'h0, lvl[31:24]}, r);
        rd(CONV_SPEED_SEL_OFF_MODE, r);
        chk("end_clr", 32'h3, r);
        rd(CONV_SPEED_SEL_OFF_IRQ_STAT, r);
        chk("stat_clr", 32'h0, r);
        chk("irq_clr", 32'h0, {31'h0, irq});
        for (int i = 0; i < 3; i++) begin
            rd(CONV_SPEED_SEL_OFF_RES_A + 8'(4 * i), r);
            chk("res_other", 32'h0, r);
        end
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk("slverr", 32'h1, {31'h0, e});
        // Low-speed single scan of inputs 4 to 6
        wr(CONV_SPEED_SEL_OFF_MODE, 32'h6E);
        rd(CONV_SPEED_SEL_OFF_PORT, r);
        chk("port_busy", 32'h0A, r);
        wait_idle(r);
        chk("scan_end", 32'h12E, r);
        // Inputs 4 to 6 land in a to c; d still holds input 3
        for (int i = 0; i < 4; i++) begin
            x = (i < 3) ? lvl[8 * (i + 4) +: 8] : lvl[31:24];
            rd(CONV_SPEED_SEL_OFF_RES_A + 8'(4 * i), r);
            chk("res_scan", {24'h0, x}, r);
        end
        rd(CONV_SPEED_SEL_OFF_PORT, r);
        chk("port_idle", 32'h6A, r);
        // Low-speed fixed repeat on input 1
        wr(CONV_SPEED_SEL_OFF_IRQ_EN, 32'h2);
        wr(CONV_SPEED_SEL_OFF_MODE, 32'h71);
        wait_evt();
        chk("irq_evt", 32'h1, {31'h0, irq});
        wr(CONV_SPEED_SEL_OFF_IRQ_EN, 32'h0);
        rd(CONV_SPEED_SEL_OFF_IRQ_STAT, r);
        chk("irq_mask", 32'h0, {31'h0, irq});
        chk("no_done", 32'h0, {31'h0, r[CONV_SPEED_SEL_EV_DONE]});
        lvl[15:8] <= 8'h3C;
        wait_evt();
        wait_evt();
        rd(CONV_SPEED_SEL_OFF_RES_B, r);
        chk("res_rep", 32'h3C, r);
        wait_evt();
        wr(CONV_SPEED_SEL_OFF_MODE, 32'h21);
        rd(CONV_SPEED_SEL_OFF_MODE, r);
        chk("rep_off", 32'hA1, {24'h0, r[7:0]});
        wait_idle(r);
        rd(CONV_SPEED_SEL_OFF_RES_B, r);
        chk("res_last", 32'h3C, r);
        // Second reset in mid-run
        wr(CONV_SPEED_SEL_OFF_MODE, 32'h7F);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(CONV_SPEED_SEL_OFF_MODE, r);
        chk("mode_rst2", 32'h0, r);
        test_done();
    end
endmodule : tb
